// >>> rtl/wdog_base_counter.sv
// Base period counter of the watchdog, stepped by oscillator ticks.
// Assumes ticks are one-cycle pulses synchronous to aclk.
`timescale 1ns/1ps
`default_nettype none
module wdog_base_counter (
  // Clock, reset and freeze.
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Control.
  input wire logic tick,
  input wire logic enable,
  input wire logic clear,
  input wire logic [wdog_pkg::BASE_W-1:0] limit,
  // Results.
  output logic wrap,
  output logic [wdog_pkg::BASE_W-1:0] count
);
  import wdog_pkg::*;

  logic [BASE_W-1:0] next_count;

  // Clear wins over a tick so a cleared counter never wraps early.
  always_comb begin
    next_count = count;
    wrap = 1'b0;
    if (clear || !enable) begin
      next_count = '0;
    end else if (tick) begin
      if (count >= limit - 16'h0001) begin
        wrap = 1'b1;
        next_count = '0;
      end else begin
        next_count = count + 16'h0001;
      end
    end
  end

  // Register stage.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= '0;
    end else if (ce) begin
      count <= next_count;
    end
  end

endmodule
`default_nettype wire

// >>> rtl/wdog_pkg.sv
// Shared constants, bus carriers and helpers of the watchdog block.
// Assumes a 32-bit AXI4-Lite register bus and one system clock.
package wdog_pkg;

  // Bus widths.
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;

  // Byte address of a register from its word index.
  function automatic logic [ADDR_W-1:0] wdog_byte_addr(
    input logic [ADDR_W-1:0] idx
  );
    wdog_byte_addr = {idx[ADDR_W-3:0], 2'b00};
  endfunction

  // Register indices; the byte address is four times the index.
  localparam logic [ADDR_W-1:0] IDX_OPTION = 16'h0081;
  localparam logic [ADDR_W-1:0] IDX_OPTION_ALT = 16'h0181;
  localparam logic [ADDR_W-1:0] IDX_CONFIG = 16'h2007;
  localparam logic [ADDR_W-1:0] IDX_STATUS = 16'h0003;
  localparam logic [ADDR_W-1:0] IDX_COMMAND = 16'h0004;
  localparam logic [ADDR_W-1:0] IDX_COUNT = 16'h0005;
  localparam logic [ADDR_W-1:0] ADDR_OPTION = wdog_byte_addr(IDX_OPTION);
  localparam logic [ADDR_W-1:0] ADDR_OPTION_ALT =
    wdog_byte_addr(IDX_OPTION_ALT);
  localparam logic [ADDR_W-1:0] ADDR_CONFIG = wdog_byte_addr(IDX_CONFIG);
  localparam logic [ADDR_W-1:0] ADDR_STATUS = wdog_byte_addr(IDX_STATUS);
  localparam logic [ADDR_W-1:0] ADDR_COMMAND = wdog_byte_addr(IDX_COMMAND);
  localparam logic [ADDR_W-1:0] ADDR_COUNT = wdog_byte_addr(IDX_COUNT);

  // Field positions and reset values.
  localparam logic [7:0] OPTION_RESET = 8'hff;
  localparam int OPT_ASSIGN_BIT = 3;
  localparam int OPT_RATIO_MSB = 2;
  localparam int OPT_RATIO_LSB = 0;
  localparam int CFG_ENABLE_BIT = 2;
  localparam int STAT_SLEEP_BIT = 0;
  localparam int STAT_PD_BIT = 3;
  localparam int STAT_TO_BIT = 4;
  localparam int CMD_CLEAR_BIT = 0;
  localparam int CMD_SLEEP_BIT = 1;

  // Counter widths and the default base period in oscillator ticks.
  localparam int BASE_W = 16;
  localparam int SCALE_W = 8;
  localparam logic [BASE_W-1:0] BASE_TICKS_DEFAULT = 16'h1000;

  // Bus answers.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Requests from the bus master.
  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } wdog_axil_req_t;

  // Answers of the slave.
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } wdog_axil_rsp_t;

  // Processor state as the watchdog sees it.
  typedef enum {WDOG_RUN, WDOG_SLEEP} wdog_mode_t;

  // Terminal count of the shared scaler: 0..127 for the watchdog,
  // 1..255 for Timer0; the scaler divides by one more than this.
  function automatic logic [SCALE_W-1:0] wdog_scale_limit(
    input logic [2:0] ratio,
    input logic to_watchdog
  );
    logic [SCALE_W:0] span;
    span = 9'h001 << ratio;
    if (!to_watchdog) begin
      span = span << 1;
    end
    wdog_scale_limit = SCALE_W'(span - 9'h001);
  endfunction

endpackage

// >>> rtl/wdog_scaler.sv
// Shared scaler: divides its step pulses by a terminal count.
// Assumes the caller picks the step source and the clear source.
`timescale 1ns/1ps
`default_nettype none
module wdog_scaler (
  // Clock, reset and freeze.
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Control.
  input wire logic step,
  input wire logic clear,
  input wire logic [wdog_pkg::SCALE_W-1:0] limit,
  // Results.
  output logic out,
  output logic [wdog_pkg::SCALE_W-1:0] count
);
  import wdog_pkg::*;

  logic [SCALE_W-1:0] next_count;

  // A ratio change mid-count applies at once; a count already at or past the new limit ends on the next step.
  always_comb begin
    next_count = count;
    out = 1'b0;
    if (clear) begin
      next_count = '0;
    end else if (step) begin
      if (count >= limit) begin
        out = 1'b1;
        next_count = '0;
      end else begin
        next_count = count + 8'h01;
      end
    end
  end

  // Register stage.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= '0;
    end else if (ce) begin
      count <= next_count;
    end
  end

endmodule
`default_nettype wire

// >>> rtl/wdog_timer.sv
// Watchdog timer with shared Timer0/watchdog scaler and AXI4-Lite regs.
// Assumes oscillator ticks and Timer0 ticks arrive as aclk-synchronous
// pulses, and that watchdog_reset is taken by the device reset logic.
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Counter runs on own oscillator, also in sleep.
// - Expiry while running gives full device reset.
// - Expiry in sleep wakes device, no reset.
// - Every expiry clears the active-low timeout flag.
// - Enable fuse at zero disables watchdog until the next reset.
// - One scaler shared, select bit and ratio bits.
// - Clear or sleep zeroes count and assigned scaler.
// - Clearing scaler leaves select and ratio unchanged.
module wdog_timer #(
  parameter logic [wdog_pkg::BASE_W-1:0] BASE_TICKS =
    wdog_pkg::BASE_TICKS_DEFAULT
) (
  // Clock, reset and freeze.
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Register bus.
  input wire wdog_pkg::wdog_axil_req_t s_axil_req,
  output wdog_pkg::wdog_axil_rsp_t s_axil_rsp,
  // Oscillator, fuse and wake sources.
  input wire logic rc_osc_tick,
  input wire logic watchdog_enable_fuse,
  input wire logic ext_wake_event,
  // Timer0 side of the shared scaler.
  input wire logic tmr0_tick,
  input wire logic tmr0_scaler_clear,
  output logic tmr0_scaled_tick,
  // Device effects.
  output logic watchdog_reset,
  output logic wake_pulse,
  output logic sleeping,
  output logic timeout_flag_n
);
  import wdog_pkg::*;

  // Bus slave state.
  wdog_axil_rsp_t next_rsp;
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [ADDR_W-1:0] aw_addr, next_aw_addr;
  logic [DATA_W-1:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic wr_fire, wr_ok, wr_option, wr_cmd, rd_ok;
  logic [DATA_W-1:0] rd_data;

  // Watchdog state.
  logic [7:0] option, next_option;
  wdog_mode_t mode, next_mode;
  logic power_down_n, next_power_down_n, next_timeout_flag_n;
  logic next_watchdog_reset, next_wake_pulse, next_tmr0_scaled_tick;
  logic fuse_en, fuse_done;
  logic cmd_clear, cmd_sleep, wdog_clear, expiry;
  logic scaler_assign_select, base_wrap, scale_step, scale_clear, scale_out;
  logic [SCALE_W-1:0] scale_limit, scale_count;
  logic [BASE_W-1:0] base_count;

  // Register decode for the held write and the offered read.
  always_comb begin
    wr_ok = (aw_addr == ADDR_OPTION) || (aw_addr == ADDR_OPTION_ALT) ||
      (aw_addr == ADDR_COMMAND);
    wr_option = wr_fire && w_strb[0] &&
      ((aw_addr == ADDR_OPTION) || (aw_addr == ADDR_OPTION_ALT));
    wr_cmd = wr_fire && w_strb[0] && (aw_addr == ADDR_COMMAND);
    rd_ok = 1'b1;
    rd_data = '0;
    case (s_axil_req.araddr)
      ADDR_OPTION, ADDR_OPTION_ALT: rd_data[7:0] = option;
      ADDR_CONFIG: rd_data[CFG_ENABLE_BIT] = fuse_en;
      ADDR_STATUS: begin
        rd_data[STAT_SLEEP_BIT] = sleeping;
        rd_data[STAT_PD_BIT] = power_down_n;
        rd_data[STAT_TO_BIT] = timeout_flag_n;
      end
      ADDR_COMMAND: rd_data = '0;
      ADDR_COUNT: rd_data = {8'h00, scale_count, base_count};
      default: rd_ok = 1'b0;
    endcase
  end

  // AXI4-Lite slave: address and data are taken in either order and one
  // write completes once both are held; each ready drops while its half is
  // held or a response is outstanding, which is the write back-pressure.
  always_comb begin
    next_rsp = s_axil_rsp;
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    wr_fire = 1'b0;
    if (s_axil_req.awvalid && s_axil_rsp.awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axil_req.awaddr;
    end
    if (s_axil_req.wvalid && s_axil_rsp.wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axil_req.wdata;
      next_w_strb = s_axil_req.wstrb;
    end
    if (s_axil_rsp.bvalid && s_axil_req.bready) begin
      next_rsp.bvalid = 1'b0;
    end
    if (aw_held && w_held && !s_axil_rsp.bvalid) begin
      wr_fire = 1'b1;
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_rsp.bvalid = 1'b1;
      next_rsp.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    next_rsp.awready = !next_aw_held && !next_rsp.bvalid;
    next_rsp.wready = !next_w_held && !next_rsp.bvalid;
    if (s_axil_req.arvalid && s_axil_rsp.arready) begin
      next_rsp.rvalid = 1'b1;
      next_rsp.rdata = rd_data;
      next_rsp.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axil_rsp.rvalid && s_axil_req.rready) begin
      next_rsp.rvalid = 1'b0;
    end
    next_rsp.arready = !next_rsp.rvalid;
  end

  // Bus slave registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axil_rsp <= '0;
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (ce) begin
      s_axil_rsp <= next_rsp;
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
    end
  end

  // The fuse is a strap: caught once after reset release, then fixed
  // until the next reset, so software cannot re-enable the watchdog.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fuse_en <= 1'b0;
      fuse_done <= 1'b0;
    end else if (ce && !fuse_done) begin
      fuse_en <= watchdog_enable_fuse;
      fuse_done <= 1'b1;
    end
  end

  // Scaler routing: the select bit hands the one scaler to either side.
  always_comb begin
    scaler_assign_select = option[OPT_ASSIGN_BIT];
    cmd_clear = wr_cmd && w_data[CMD_CLEAR_BIT];
    cmd_sleep = wr_cmd && w_data[CMD_SLEEP_BIT];
    wdog_clear = cmd_clear || cmd_sleep;
    scale_limit = wdog_scale_limit(option[OPT_RATIO_MSB:OPT_RATIO_LSB],
      scaler_assign_select);
    scale_step = scaler_assign_select ? base_wrap : tmr0_tick;
    scale_clear = scaler_assign_select ? wdog_clear
      : tmr0_scaler_clear;
    expiry = fuse_en && (scaler_assign_select ? scale_out : base_wrap);
  end

  // Base counter steps on every oscillator tick, asleep or awake.
  wdog_base_counter u_base (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .tick(rc_osc_tick),
    .enable(fuse_en),
    .clear(wdog_clear),
    .limit(BASE_TICKS),
    .wrap(base_wrap),
    .count(base_count)
  );

  // Shared scaler.
  wdog_scaler u_scale (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .step(scale_step),
    .clear(scale_clear),
    .limit(scale_limit),
    .out(scale_out),
    .count(scale_count)
  );

  // Mode, flags and device effects. An expiry is applied after the
  // commands so that a timeout flag cleared by hardware is never lost
  // to a software clear in the same cycle.
  always_comb begin
    next_option = option;
    next_mode = mode;
    next_power_down_n = power_down_n;
    next_timeout_flag_n = timeout_flag_n;
    next_watchdog_reset = 1'b0;
    next_wake_pulse = 1'b0;
    next_tmr0_scaled_tick = !scaler_assign_select && scale_out;
    if (wr_option) begin
      next_option = w_data[7:0];
    end
    case (mode)
      WDOG_RUN: begin
        if (cmd_sleep) begin
          next_mode = WDOG_SLEEP;
        end
      end
      WDOG_SLEEP: begin
        if (ext_wake_event) begin
          next_mode = WDOG_RUN;
          next_wake_pulse = 1'b1;
        end
      end
      default: next_mode = WDOG_RUN;
    endcase
    if (cmd_clear) begin
      next_timeout_flag_n = 1'b1;
      next_power_down_n = 1'b1;
    end
    if (cmd_sleep) begin
      next_timeout_flag_n = 1'b1;
      next_power_down_n = 1'b0;
    end
    if (expiry) begin
      next_timeout_flag_n = 1'b0;
      if (mode == WDOG_SLEEP) begin
        next_mode = WDOG_RUN;
        next_wake_pulse = 1'b1;
      end else begin
        next_mode = WDOG_RUN;
        next_watchdog_reset = 1'b1;
      end
    end
  end

  // Watchdog registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      option <= OPTION_RESET;
      mode <= WDOG_RUN;
      sleeping <= 1'b0;
      power_down_n <= 1'b1;
      timeout_flag_n <= 1'b1;
      watchdog_reset <= 1'b0;
      wake_pulse <= 1'b0;
      tmr0_scaled_tick <= 1'b0;
    end else if (ce) begin
      option <= next_option;
      mode <= next_mode;
      sleeping <= (next_mode == WDOG_SLEEP);
      power_down_n <= next_power_down_n;
      timeout_flag_n <= next_timeout_flag_n;
      watchdog_reset <= next_watchdog_reset;
      wake_pulse <= next_wake_pulse;
      tmr0_scaled_tick <= next_tmr0_scaled_tick;
    end
  end

  // Checks on the watchdog behaviour.
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn || !ce);

  a_reset_on_run: assert property (
    expiry && mode == WDOG_RUN |=> watchdog_reset && !wake_pulse)
    else $error("expiry while running gave no reset");
  a_wake_in_sleep: assert property (
    expiry && mode == WDOG_SLEEP |=> wake_pulse && !watchdog_reset && !sleeping)
    else $error("expiry in sleep did not wake cleanly");
  a_flag_cleared: assert property (
    expiry |=> !timeout_flag_n)
    else $error("timeout flag not cleared by expiry");
  a_fuse_blocks: assert property (
    !fuse_en |-> !base_wrap && base_count == '0 && !watchdog_reset)
    else $error("disabled watchdog expired");
  a_sleep_counts: assert property (
    mode == WDOG_SLEEP && rc_osc_tick && fuse_en && !base_wrap && !wdog_clear
    |=> base_count == $past(base_count) + 16'h0001)
    else $error("counter stalled in sleep");
  a_scaler_routed: assert property (
    !scaler_assign_select && scale_out |=> tmr0_scaled_tick)
    else $error("scaler tick not routed to Timer0");
  a_clear_zeroes: assert property (
    wdog_clear |=> base_count == '0 &&
      (!scaler_assign_select || scale_count == '0))
    else $error("clear did not zero the counts");
  a_clear_keeps_opt: assert property (
    cmd_clear && !wr_option |=> option == $past(option))
    else $error("clear changed the option register");
  a_bus_answer: assert property (
    aw_held && w_held && !s_axil_rsp.bvalid |=> s_axil_rsp.bvalid)
    else $error("write response missing");

  c_reset: cover property (expiry && mode == WDOG_RUN);
  c_wake: cover property (expiry && mode == WDOG_SLEEP);
  c_tmr0: cover property (tmr0_scaled_tick);
  c_clear: cover property (cmd_clear ##1 s_axil_rsp.bvalid);

endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking testbench of the watchdog block, driven over AXI4-Lite.
// Assumes the design package and BASE_TICKS set to 4 to keep runs short.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import wdog_pkg::*;
  localparam logic [BASE_W-1:0] BT = 16'h0004;
  logic aclk;
  logic aresetn;
  logic rc_osc_tick;
  logic fuse;
  logic ext_wake;
  logic t0_tick;
  logic t0_clr;
  logic wd_rst;
  logic wake;
  logic sleeping;
  logic flag_n;
  logic t0_out;
  wdog_axil_req_t req;
  wdog_axil_rsp_t rsp;
  int n_mismatch;
  int checks_done;
  int n_rst;
  int n_wake;
  int n_t0;
  logic [1:0] resp;
  logic [31:0] rd;

  // The clock enable is tied high; freezing is not exercised here.
  wdog_timer #(.BASE_TICKS(BT)) u_wdog_timer (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axil_req(req), .s_axil_rsp(rsp),
    .rc_osc_tick(rc_osc_tick), .watchdog_enable_fuse(fuse),
    .ext_wake_event(ext_wake), .tmr0_tick(t0_tick),
    .tmr0_scaler_clear(t0_clr), .tmr0_scaled_tick(t0_out),
    .watchdog_reset(wd_rst), .wake_pulse(wake),
    .sleeping(sleeping), .timeout_flag_n(flag_n)
  );

  // A 200 MHz clock.
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // Pulses are counted so that no single cycle has to be hit exactly.
  always @(posedge aclk) begin
    if (wd_rst === 1'b1) n_rst++;
    if (wake === 1'b1) n_wake++;
    if (t0_out === 1'b1) n_t0++;
  end

  // Compares a value seen against the value expected.
  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One write; address and data are offered together, bready held up.
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && rsp.awready === 1'b1) begin
        aw_done = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (!w_done && rsp.wready === 1'b1) begin
        w_done = 1'b1;
        req.wvalid <= 1'b0;
      end
    end
    while (rsp.bvalid !== 1'b1) @(posedge aclk);
    resp = rsp.bresp;
    req.bready <= 1'b0;
  endtask

  // One read; the data and code are taken at the rvalid edge.
  task automatic rdr(input logic [15:0] a);
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do @(posedge aclk); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge aclk); while (rsp.rvalid !== 1'b1);
    rd = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  // Pulses: 0 oscillator tick, 1 Timer0 tick, 2 Timer0 scaler clear.
  task automatic pulse(input int which, input int n);
    repeat (n) begin
      @(posedge aclk);
      if (which == 0) rc_osc_tick <= 1'b1;
      else if (which == 1) t0_tick <= 1'b1;
      else t0_clr <= 1'b1;
      @(posedge aclk);
      rc_osc_tick <= 1'b0;
      t0_tick <= 1'b0;
      t0_clr <= 1'b0;
    end
    repeat (3) @(posedge aclk);
  endtask

  // Reset for 20 cycles with the given fuse strap.
  task automatic do_reset(input logic f);
    @(posedge aclk);
    aresetn <= 1'b0;
    fuse <= f;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // A hang is cut short well beyond the expected run length.
  initial begin
    #200us;
    n_mismatch++;
    $display("timeout reached");
    end_sim;
  end

  // Main sequence.
  initial begin
    req = '0;
    aresetn = 1'b0;
    fuse = 1'b1;
    rc_osc_tick = 1'b0;
    ext_wake = 1'b0;
    t0_tick = 1'b0;
    t0_clr = 1'b0;
    do_reset(1'b1);
    rdr(ADDR_OPTION);
    chk("option reset", rd, 32'h000000ff);
    chk("flag reset", {31'h0, flag_n}, 32'h1);
    rdr(ADDR_CONFIG);
    chk("fuse on", {31'h0, rd[CFG_ENABLE_BIT]}, 32'h1);
    wr(16'h0100, 32'h0);
    chk("unmapped", {30'h0, resp}, {30'h0, RESP_SLVERR});
    $display("test reset done");
    // Ratio 1 to the watchdog: expiry on the fourth tick while running.
    wr(ADDR_OPTION, 32'h08);
    wr(ADDR_COMMAND, 32'h1);
    pulse(0, 3);
    chk("no early reset", n_rst, 0);
    pulse(0, 1);
    chk("reset pulse", n_rst, 1);
    chk("flag low", {31'h0, flag_n}, 32'h0);
    chk("no wake", n_wake, 0);
    wr(ADDR_COMMAND, 32'h1);
    chk("flag restored", {31'h0, flag_n}, 32'h1);
    pulse(0, 3);
    wr(ADDR_COMMAND, 32'h1);
    rdr(ADDR_COUNT);
    chk("count cleared", rd, 32'h0);
    pulse(0, 3);
    chk("clear holds off", n_rst, 1);
    $display("test run expiry done");
    // Ratio 2: two wraps of the base count are needed.
    wr(ADDR_OPTION, 32'h09);
    wr(ADDR_COMMAND, 32'h1);
    pulse(0, 7);
    chk("ratio 2 early", n_rst, 1);
    pulse(0, 1);
    chk("ratio 2 expiry", n_rst, 2);
    rdr(ADDR_OPTION);
    chk("option kept", rd, 32'h00000009);
    rdr(ADDR_OPTION_ALT);
    chk("option alias", rd, 32'h00000009);
    $display("test ratio done");
    // Expiry in sleep wakes and does not reset.
    wr(ADDR_OPTION, 32'h08);
    wr(ADDR_COMMAND, 32'h2);
    @(posedge aclk);
    chk("asleep", {31'h0, sleeping}, 32'h1);
    pulse(0, 4);
    chk("sleep wake", n_wake, 1);
    chk("sleep no reset", n_rst, 2);
    chk("awake", {31'h0, sleeping}, 32'h0);
    rdr(ADDR_STATUS);
    chk("status flag", {31'h0, rd[STAT_TO_BIT]}, 32'h0);
    chk("status pd", {31'h0, rd[STAT_PD_BIT]}, 32'h0);
    // Another wake source leaves the flag set.
    wr(ADDR_COMMAND, 32'h1);
    wr(ADDR_COMMAND, 32'h2);
    @(posedge aclk);
    ext_wake <= 1'b1;
    @(posedge aclk);
    ext_wake <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("ext wake", n_wake, 2);
    chk("ext flag", {31'h0, flag_n}, 32'h1);
    $display("test sleep done");
    // Scaler to Timer0: divide by two; the watchdog expires every wrap.
    wr(ADDR_OPTION, 32'h00);
    wr(ADDR_COMMAND, 32'h1);
    pulse(2, 1);
    pulse(1, 4);
    chk("timer0 ticks", n_t0, 2);
    pulse(0, 4);
    chk("unscaled expiry", n_rst, 3);
    $display("test timer0 done");
    // Fuse cleared: never a time-out.
    do_reset(1'b0);
    rdr(ADDR_CONFIG);
    chk("fuse off", {31'h0, rd[CFG_ENABLE_BIT]}, 32'h0);
    wr(ADDR_OPTION, 32'h08);
    wr(ADDR_COMMAND, 32'h1);
    pulse(0, 8);
    chk("disabled", n_rst, 3);
    chk("disabled flag", {31'h0, flag_n}, 32'h1);
    $display("test fuse done");
    end_sim;
  end
endmodule
`default_nettype wire
